// File: gcr_defines.vh
// Purpose: shared constants of the pin control and calibration registers
// Assumes: register index times four gives the AHB-Lite byte address
// Notes:   definitions only, no logic
`ifndef GCR_DEFINES_VH
`define GCR_DEFINES_VH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define GCR_IDX_CLOCK_OUT 8'h02
`define GCR_IDX_PIN_CONTROL 8'h04
`define GCR_IDX_OFFSET_LOW 8'h05
`define GCR_IDX_OFFSET_MID 8'h06
`define GCR_IDX_OFFSET_HIGH 8'h07
`define GCR_IDX_GAIN_LOW 8'h08
`define GCR_IDX_GAIN_MID 8'h09
`define GCR_IDX_GAIN_HIGH 8'h0a
`define GCR_ADDR_SHIFT 2
`define GCR_ADDR_LSB_MASK 2'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define GCR_CLK_SEL_HI 6
`define GCR_CLK_SEL_LO 5
`define GCR_PIN_RSV7 7
`define GCR_PIN_RSV6 6
`define GCR_PIN_B_DIR 5
`define GCR_PIN_A_DIR 4
`define GCR_PIN_RSV3 3
`define GCR_PIN_RSV2 2
`define GCR_PIN_B_STATE 1
`define GCR_PIN_A_STATE 0

// ----------------------------------------------------------------------
// field encodings and reset values
// ----------------------------------------------------------------------
`define GCR_CLK_OFF 2'h0
`define GCR_CLK_DIV1 2'h1
`define GCR_CLK_DIV2 2'h2
`define GCR_CLK_DIV4 2'h3
`define GCR_CLK_SEL_RESET 2'h1
`define GCR_PIN_CONTROL_RESET 8'he0
`define GCR_HTRANS_NONSEQ 2'h2

`endif

// File: gcr_clk_div.v
// Purpose: divide-by-two and divide-by-four clock taps for the pin a output
// Assumes: runs on the converter input clock
// Notes:   both taps come straight from flip-flops, so they are glitch free

module gcr_clk_div (
  input wire ref_clk,
  input wire reset_n,
  output wire divBy2,
  output wire divBy4
);

  reg [1:0] divCount;

  // ----------------------------------------------------------------------
  // free-running two-bit counter
  // ----------------------------------------------------------------------
  // counter bits are the divided clocks themselves
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCount <= 2'h0;
    end else begin
      divCount <= divCount + 2'h1;
    end
  end

  assign divBy2 = divCount[0];
  assign divBy4 = divCount[1];

endmodule

// File: gcr_gpio_cal.v
// Purpose: two-pin digital i/o port and calibration register bank
// Assumes: AHB-Lite single word transfers; pins settle outside our clock
// Notes:   calibration registers have no reset; the converter loads them
//
// Implementation choice: the AHB-Lite interface to the registers.

`include "gcr_defines.vh"

// Functional notes
// RL1 - pin b direction: 0 output, 1 input
// RL2 - pin a direction: 0 output, 1 input
// RL3 - pin b state reads actual pin level
// RL4 - pin b output: write sets driven level
// RL5 - pin b input: state write ignored
// RL6 - pin a input: state reads pin level
// RL7 - pin a input: state write no effect
// RL8 - pin a output, clock off: write drives
// RL9 - pin a output, clock on: carries clock
// RL10 - offset correction in three byte registers
// RL11 - gain correction in three byte registers
// RL12 - calibration registers not reset to constants
// RL13 - clock select: off, /1, /2, /4
// RL14 - software writes reserved bits as documented
module gcr_gpio_cal (
  input wire ref_clk,
  input wire reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // converter calibration load
  input wire calLoad,
  input wire [23:0] calOffset,
  input wire [23:0] calGain,
  output reg [23:0] offsetCorrection,
  output reg [23:0] gainCorrection,
  // pin a, shared with clock output
  input wire gpioPinAClockOutIn,
  output wire gpioPinAClockOut,
  output reg gpioPinAClockOutOe,
  // pin b
  input wire gpioPinBIn,
  output reg gpioPinBOut,
  output reg gpioPinBOe
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [1:0] clkSel;
  reg [1:0] pinRsvHigh;
  reg [1:0] pinRsvLow;
  reg pinBDirection;
  reg pinADirection;
  reg pinAState;
  reg pinBState;
  reg pinASync1;
  reg pinASync2;
  reg pinBSync1;
  reg pinBSync2;
  reg writePending;
  reg [5:0] writeIndex;
  reg readPending;
  reg [5:0] readIndex;
  reg pinADrive;
  reg clkPassThrough;
  reg [7:0] next_readByte;
  wire addrPhase;
  wire [5:0] addrIndex;
  wire addrAligned;
  wire [7:0] wrByte;
  wire divBy2;
  wire divBy4;
  wire pinAWriteOk;
  wire pinBWriteOk;

  // ----------------------------------------------------------------------
  // reset images
  // ----------------------------------------------------------------------
  // pin control whole-register image, sliced per field, and clock select field constant, so each field resets to
  // exactly the bits the register shows after reset, except the two state bits, which read the pin levels
  localparam [7:0] PIN_RESET = `GCR_PIN_CONTROL_RESET;
  localparam [1:0] CLK_RESET = `GCR_CLK_SEL_RESET;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // register index from a byte address
  function [5:0] regIndex;
    input [7:0] addr;
    begin
      regIndex = addr[7:2];
    end
  endfunction

  // true when a latched index selects the given register
  function isReg;
    input [5:0] idx;
    input [7:0] regIdx;
    begin
      isReg = (idx == regIdx[5:0]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // clock divider
  // ----------------------------------------------------------------------
  gcr_clk_div u_clk_div (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .divBy2(divBy2),
    .divBy4(divBy4)
  );

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // pins change with no regard to our clock, so two flops each
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinASync1 <= 1'b0;
      pinASync2 <= 1'b0;
      pinBSync1 <= 1'b0;
      pinBSync2 <= 1'b0;
    end else begin
      pinASync1 <= gpioPinAClockOutIn;
      pinASync2 <= pinASync1;
      pinBSync1 <= gpioPinBIn;
      pinBSync2 <= pinBSync1;
    end
  end

  // ----------------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------------
  // a transfer is taken only when the bus is ready
  assign addrPhase = hsel & hready & (htrans == `GCR_HTRANS_NONSEQ);
  assign addrIndex = regIndex(haddr);
  assign addrAligned = (haddr[1:0] == `GCR_ADDR_LSB_MASK);
  assign wrByte = hwdata[7:0];

  // writes complete with no wait; reads take one wait state so the
  // read mux sees a write that finished in the same edge
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      writePending <= 1'b0;
      writeIndex <= 6'h00;
      readPending <= 1'b0;
      readIndex <= 6'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      // hresp is never raised: every transfer is okay
      hresp <= 1'b0;
      writePending <= addrPhase & hwrite & addrAligned;
      if (addrPhase) begin
        writeIndex <= addrIndex;
        readIndex <= addrIndex;
      end
      if (addrPhase && !hwrite) begin
        readPending <= 1'b1;
        hreadyout <= 1'b0;
      end else if (readPending) begin
        readPending <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= {24'h000000, next_readByte};
      end else begin
        hreadyout <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // unmapped addresses read as zero
  always @* begin
    next_readByte = 8'h00;
    // index widened to the width of the register index constants
    case ({2'h0, readIndex})
      `GCR_IDX_CLOCK_OUT: begin
        next_readByte[`GCR_CLK_SEL_HI:`GCR_CLK_SEL_LO] = clkSel;
      end
      `GCR_IDX_PIN_CONTROL: begin
        next_readByte[`GCR_PIN_RSV7:`GCR_PIN_RSV6] = pinRsvHigh;
        next_readByte[`GCR_PIN_B_DIR] = pinBDirection;
        next_readByte[`GCR_PIN_A_DIR] = pinADirection;
        next_readByte[`GCR_PIN_RSV3:`GCR_PIN_RSV2] = pinRsvLow;
        // RL3 pin b level
        next_readByte[`GCR_PIN_B_STATE] = pinBSync2;
        // RL6 pin a level
        next_readByte[`GCR_PIN_A_STATE] = pinASync2;
      end
      // RL10 offset byte order
      `GCR_IDX_OFFSET_LOW: begin
        next_readByte = offsetCorrection[7:0];
      end
      `GCR_IDX_OFFSET_MID: begin
        next_readByte = offsetCorrection[15:8];
      end
      `GCR_IDX_OFFSET_HIGH: begin
        next_readByte = offsetCorrection[23:16];
      end
      // RL11 gain byte order
      `GCR_IDX_GAIN_LOW: begin
        next_readByte = gainCorrection[7:0];
      end
      `GCR_IDX_GAIN_MID: begin
        next_readByte = gainCorrection[15:8];
      end
      `GCR_IDX_GAIN_HIGH: begin
        next_readByte = gainCorrection[23:16];
      end
      default: begin
        next_readByte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // state writes are gated by the direction held before the write
  // RL5 pin b input ignores
  assign pinBWriteOk = ~pinBDirection;
  // RL7 pin a input ignores
  assign pinAWriteOk = ~pinADirection & (clkSel == `GCR_CLK_OFF);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkSel <= CLK_RESET;
      pinRsvHigh <= PIN_RESET[`GCR_PIN_RSV7:`GCR_PIN_RSV6];
      // RL1 input after reset
      pinBDirection <= PIN_RESET[`GCR_PIN_B_DIR];
      pinADirection <= PIN_RESET[`GCR_PIN_A_DIR];
      pinRsvLow <= PIN_RESET[`GCR_PIN_RSV3:`GCR_PIN_RSV2];
      pinBState <= PIN_RESET[`GCR_PIN_B_STATE];
      pinAState <= PIN_RESET[`GCR_PIN_A_STATE];
    end else if (writePending) begin
      if (isReg(writeIndex, `GCR_IDX_CLOCK_OUT)) begin
        clkSel <= wrByte[`GCR_CLK_SEL_HI:`GCR_CLK_SEL_LO];
      end
      if (isReg(writeIndex, `GCR_IDX_PIN_CONTROL)) begin
        // RL14 reserved bits kept
        pinRsvHigh <= wrByte[`GCR_PIN_RSV7:`GCR_PIN_RSV6];
        pinRsvLow <= wrByte[`GCR_PIN_RSV3:`GCR_PIN_RSV2];
        // RL1 pin b direction
        pinBDirection <= wrByte[`GCR_PIN_B_DIR];
        // RL2 pin a direction
        pinADirection <= wrByte[`GCR_PIN_A_DIR];
        // RL4 pin b level
        if (pinBWriteOk) begin
          pinBState <= wrByte[`GCR_PIN_B_STATE];
        end
        // RL8 pin a level
        if (pinAWriteOk) begin
          pinAState <= wrByte[`GCR_PIN_A_STATE];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // calibration registers
  // ----------------------------------------------------------------------
  // RL12 no reset value
  // the converter's load wins over a bus write in the same edge
  // until the first load or write these read back as unknown
  always @(posedge ref_clk) begin
    if (calLoad) begin
      offsetCorrection <= calOffset;
      gainCorrection <= calGain;
    end else if (writePending) begin
      // RL10 offset bytes
      if (isReg(writeIndex, `GCR_IDX_OFFSET_LOW)) begin
        offsetCorrection[7:0] <= wrByte;
      end
      if (isReg(writeIndex, `GCR_IDX_OFFSET_MID)) begin
        offsetCorrection[15:8] <= wrByte;
      end
      if (isReg(writeIndex, `GCR_IDX_OFFSET_HIGH)) begin
        offsetCorrection[23:16] <= wrByte;
      end
      // RL11 gain bytes
      if (isReg(writeIndex, `GCR_IDX_GAIN_LOW)) begin
        gainCorrection[7:0] <= wrByte;
      end
      if (isReg(writeIndex, `GCR_IDX_GAIN_MID)) begin
        gainCorrection[15:8] <= wrByte;
      end
      if (isReg(writeIndex, `GCR_IDX_GAIN_HIGH)) begin
        gainCorrection[23:16] <= wrByte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // RL13 clock select decode
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinADrive <= 1'b0;
      clkPassThrough <= 1'b0;
      gpioPinAClockOutOe <= 1'b0;
      gpioPinBOut <= 1'b0;
      gpioPinBOe <= 1'b0;
    end else begin
      // RL9 clock owns pin a
      clkPassThrough <= (clkSel == `GCR_CLK_DIV1);
      // divided taps pass one more flop so the pin never glitches
      case (clkSel)
        `GCR_CLK_DIV2: begin
          pinADrive <= divBy2;
        end
        `GCR_CLK_DIV4: begin
          pinADrive <= divBy4;
        end
        `GCR_CLK_OFF: begin
          pinADrive <= pinAState;
        end
        default: begin
          pinADrive <= 1'b0;
        end
      endcase
      // RL2 pin a enable
      gpioPinAClockOutOe <= ~pinADirection;
      // RL1 pin b enable
      gpioPinBOe <= ~pinBDirection;
      // RL4 pin b level
      gpioPinBOut <= pinBState;
    end
  end

  // the undivided clock cannot come from a flop, so it is muxed in
  assign gpioPinAClockOut = clkPassThrough ? ref_clk : pinADrive;

endmodule

// File: gcr_gpio_cal_checker.sv
// Purpose: bus and pin timing checks on the gcr_gpio_cal ports
// Assumes: single word AHB-Lite transfers, pin control at byte 8'h10
// Notes:   pin reads checked only after the pin was quiet for a while
module gcr_gpio_cal_checker (
  input wire ref_clk,
  input wire reset_n,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire gpioPinAClockOutIn,
  input wire gpioPinAClockOut,
  input wire gpioPinAClockOutOe,
  input wire gpioPinBIn,
  input wire gpioPinBOut,
  input wire gpioPinBOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // decoded address phases
  // ----
  wire take = hsel && hready && htrans == 2'h2;
  wire wrPin = take && hwrite && haddr == 8'h10;
  wire rdPin = take && !hwrite && haddr == 8'h10;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // ----
  // assertions
  // ----
  AST_RESP_OKAY:
    assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_READ_WAIT:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_PINB_DIR:
    assert property (wrPin ##1 1 |-> ##2 gpioPinBOe == !$past(hwdata[5], 2))
    else $error("pin b enable wrong");
  AST_PINA_DIR:
    assert property (wrPin ##1 1 |->
      ##2 gpioPinAClockOutOe == !$past(hwdata[4], 2))
    else $error("pin a enable wrong");
  AST_PINB_READ:
    assert property ($stable(gpioPinBIn) [*5] ##0 rdPin |->
      ##2 hrdata[1] == $past(gpioPinBIn, 2))
    else $error("pin b level read wrong");
  AST_PINA_READ:
    assert property ((!gpioPinAClockOutOe && $stable(gpioPinAClockOutIn)) [*5]
      ##0 rdPin |-> ##2 hrdata[0] == $past(gpioPinAClockOutIn, 2))
    else $error("pin a level read wrong");
  // enable sampled two edges on is the direction that gated the write
  AST_PINB_DRIVE:
    assert property (wrPin ##2 gpioPinBOe |->
      ##1 gpioPinBOut == $past(hwdata[1], 2))
    else $error("pin b drive wrong");
  AST_PINB_HOLD:
    assert property (wrPin ##2 !gpioPinBOe |-> ##1 $stable(gpioPinBOut))
    else $error("pin b changed while input");
  AST_CLK_DIV2:
    assert property (take && hwrite && haddr == 8'h08 ##1 hwdata[6:5] == 2'h2
      |-> ##4 $changed(gpioPinAClockOut) [*4])
    else $error("half rate clock missing");
  CV_PIN_WRITE: cover property (wrPin);
  CV_PIN_READ: cover property (rdPin ##2 hrdata[1]);
  CV_PINB_OUT: cover property (gpioPinBOe && gpioPinBOut);
endmodule

bind gcr_gpio_cal gcr_gpio_cal_checker chk_u (
  .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .gpioPinAClockOutIn(gpioPinAClockOutIn),
  .gpioPinAClockOut(gpioPinAClockOut),
  .gpioPinAClockOutOe(gpioPinAClockOutOe), .gpioPinBIn(gpioPinBIn),
  .gpioPinBOut(gpioPinBOut), .gpioPinBOe(gpioPinBOe)
);

// File: gcr_pin_model.sv
// Purpose: external circuits on the two pins
// Assumes: no pulls, so the load drives whenever the port does not
// Notes:   slow mode lets pin b settle 60 ns after a change
module gcr_pin_model (
  input wire logic aOe,
  input wire logic aOut,
  input wire logic bOe,
  input wire logic bOut,
  input wire logic aDrive,
  input wire logic bDrive,
  input wire logic slow,
  output wire logic aWire,
  output wire logic bWire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bLate = 1'b0;
  // late copy of the load level, a slow external driver
  always @(bDrive) bLate <= #60 bDrive;
  // wire level: whoever has the enable wins
  assign aWire = aOe ? aOut : aDrive;
  assign bWire = bOe ? bOut : (slow ? bLate : bDrive);
endmodule

// File: tb_gpio_and_calibration_regs.sv
// Purpose: self-checking bench for the pin and calibration registers
// Assumes: one AHB-Lite master, pins loaded by gcr_pin_model
// Notes:   clock modes checked by counting pin a toggles
module tb_gpio_and_calibration_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic refClk = 0, resetN = 0, hsel = 0, hwrite = 0, calLoad = 0;
  logic aDrive = 0, bDrive = 0, slow = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, rd;
  logic [23:0] calOffset = 0, calGain = 0;
  wire hreadyout, hresp, aOut, aOe, bOut, bOe, aWire, bWire;
  wire [31:0] hrdata;
  wire [23:0] ofs, gain;
  int n_mismatch = 0, check_count = 0;
  int tgl[4] = '{0, 0, 16, 8};
  // 20 MHz reference clock
  always #25 refClk = ~refClk;
  gcr_gpio_cal dut_u (.ref_clk(refClk), .reset_n(resetN), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .calLoad(calLoad),
    .calOffset(calOffset), .calGain(calGain), .offsetCorrection(ofs),
    .gainCorrection(gain), .gpioPinAClockOutIn(aWire),
    .gpioPinAClockOut(aOut), .gpioPinAClockOutOe(aOe),
    .gpioPinBIn(bWire), .gpioPinBOut(bOut), .gpioPinBOe(bOe));
  gcr_pin_model load_u (.aOe(aOe), .aOut(aOut), .bOe(bOe), .bOut(bOut),
    .aDrive(aDrive), .bDrive(bDrive), .slow(slow), .aWire(aWire),
    .bWire(bWire));
  // ----
  // tasks
  // ----
  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge refClk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk(32'h0, 32'h1);
        test_done();
      end
      @(posedge refClk);
    end
  endtask
  // one single transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge refClk);
  endtask
  // sampled mid high phase, so the pass-through clock never toggles
  task automatic toggles(input int exp);
    int c;
    logic p;
    c = 0;
    @(posedge refClk);
    #10 p = aOut;
    repeat (16) begin
      @(posedge refClk);
      #10 c += (aOut !== p);
      p = aOut;
    end
    @(posedge refClk);
    chk(c, exp);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    cyc(20);
    resetN <= 1'b1;
    cyc(3);
    chk(aOe, 1);
    chk(bOe, 0);
    xfer(0, 8'h10, 0);
    chk(rd & 32'hfffffffe, 32'he0);
    #10 chk(aOut, 1);
    #25 chk(aOut, 0);
    @(posedge refClk);
    for (int m = 0; m < 4; m++) begin
      xfer(1, 8'h08, m << 5);
      cyc(8);
      toggles(tgl[m]);
    end
    // reserved bits written as ones above, zeros below the directions
    xfer(1, 8'h10, 32'he1);
    xfer(1, 8'h08, 0);
    cyc(3);
    chk(aOut, 0);
    xfer(1, 8'h10, 32'he1);
    cyc(2);
    chk(aOut, 1);
    xfer(1, 8'h10, 32'hf1);
    cyc(2);
    chk(aOe, 0);
    aDrive <= 1'b1;
    cyc(6);
    xfer(0, 8'h10, 0);
    chk(rd[0], 1);
    xfer(1, 8'h10, 32'hf0);
    xfer(1, 8'h10, 32'he0);
    cyc(2);
    chk({aOe, aOut}, 2'h3);
    xfer(1, 8'h10, 32'he2);
    xfer(1, 8'h10, 32'hc0);
    cyc(2);
    chk({bOe, bOut}, 2'h2);
    xfer(1, 8'h10, 32'hc2);
    cyc(6);
    chk(bOut, 1);
    xfer(0, 8'h10, 0);
    chk(rd[1], 1);
    xfer(1, 8'h10, 32'he0);
    slow <= 1'b1;
    bDrive <= 1'b1;
    cyc(8);
    xfer(0, 8'h10, 0);
    chk(rd[1], 1);
    for (int i = 0; i < 6; i++) begin
      xfer(1, 8'(8'h14 + 4 * i), 32'h11 * (i + 1));
    end
    // last byte lands on the edge the task returns at
    cyc(1);
    chk(ofs, 24'h332211);
    chk(gain, 24'h665544);
    xfer(0, 8'h28, 0);
    chk(rd, 32'h66);
    calOffset <= 24'h123456;
    calGain <= 24'habcdef;
    calLoad <= 1'b1;
    @(posedge refClk);
    calLoad <= 1'b0;
    xfer(0, 8'h1c, 0);
    chk(rd, 32'h12);
    chk(gain, 24'habcdef);
    // unmapped place: write lost, read gives zero
    xfer(1, 8'h30, 32'hff);
    xfer(0, 8'h30, 0);
    chk(rd, 32'h0);
    test_done();
  end
  // overall guard against a hung run
  initial begin
    cyc(20000);
    chk(32'h0, 32'h1);
    test_done();
  end
endmodule
